// [src/rcs_pkg.sv]
// Constants, register map and state type of the reset cause and start-up sequencer
package rcs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;        // AXI4-Lite address width
  localparam logic [7:0] OFS_CAUSE = 8'h00;  // reset_cause_register
  localparam logic [7:0] OFS_STATUS = 8'h04; // Sequencer status, read only

  // ---------------------------------------------------------------
  // Reset cause field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_TRAP = 15;     // trap_conflict_flag
  localparam int unsigned BIT_ILLEGAL = 14;  // illegal_condition_flag
  localparam int unsigned BIT_CMISM = 9;     // config_mismatch_flag
  localparam int unsigned BIT_EXTPIN = 7;    // external_pin_reset_flag
  localparam int unsigned BIT_SWRST = 6;     // software_reset_flag
  localparam int unsigned BIT_SOFT_WATCHDOG_ENABLE = 5;    // soft_watchdog_enable
  localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG = 4;      // watchdog_timeout_flag
  localparam int unsigned BIT_SLEEP = 3;     // Been in sleep
  localparam int unsigned BIT_IDLE = 2;      // Been in idle
  localparam int unsigned BIT_BOR = 1;       // Brown-out flag
  localparam int unsigned BIT_POR = 0;       // Power-on flag

  // Reset value, implemented bits, bits a brown-out leaves alone
  localparam logic [15:0] CAUSE_RESET = 16'h0003;
  localparam logic [15:0] CAUSE_IMPL_MASK = 16'hC2FF;
  localparam logic [15:0] BOR_KEEP_MASK = 16'h00A1;

  // ---------------------------------------------------------------
  // Status register field positions
  // ---------------------------------------------------------------
  localparam int unsigned STAT_SYSTEM_RESET = 0;   // System reset held
  localparam int unsigned STAT_CLKRDY = 1;   // Clock ready
  localparam int unsigned STAT_FAILSAFE_CLOCK_MONITOR = 2;     // Fail-safe monitor active
  localparam int unsigned STAT_WDTEN = 3;    // Watchdog enabled
  localparam int unsigned STAT_SRC = 4;      // Clock source, 3 bits

  // ---------------------------------------------------------------
  // Oscillator mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] OSC_FRC = 3'h0;
  localparam logic [2:0] OSC_FAST_RC_WITH_PLL_MODE = 3'h1;
  localparam logic [2:0] OSC_PRI = 3'h2;     // Crystal or external clock
  localparam logic [2:0] OSC_PRIPLL = 3'h3;  // Same, with PLL
  localparam logic [2:0] OSC_SECONDARY_OSCILLATOR_MODE = 3'h4;
  localparam logic [2:0] OSC_LOW_POWER_RC_MODE = 3'h5;
  localparam logic [2:0] OSC_FRCDIV16 = 3'h6;
  localparam logic [2:0] OSC_FRCDIVN = 3'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POR_EXT_US = 30;   // power_on_extension_time, max
  localparam int unsigned BOR_EXT_US = 100;  // brownout_extension_time, max
  localparam int unsigned POWER_UP_TIMER_MS = 64;      // power_up_delay, nominal
  localparam int unsigned PLL_LOCK_US = 1500; // PLL lock wait, nominal
  localparam int unsigned FAILSAFE_CLOCK_MONITOR_US = 900;     // failsafe_monitor_delay, max
  localparam int unsigned OST_PERIODS = 1024; // Oscillator periods counted
  localparam int unsigned POR_EXT_CYC = (POR_EXT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned BOR_EXT_CYC = (BOR_EXT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned POWER_UP_TIMER_CYC = (POWER_UP_TIMER_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned FAILSAFE_CLOCK_MONITOR_CYC = (FAILSAFE_CLOCK_MONITOR_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 21;        // Holds the longest count
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_COLD_HOLD, ST_POR_EXT, ST_BOR_EXT, ST_POWER_UP_TIMER, ST_OSC_START, ST_OST, ST_PLL, ST_WARM, ST_RUN
  } rcs_state_e;

endpackage : rcs_pkg

// [src/rcs_sequencer.sv]
// Reset cause register and system reset / clock start-up sequencer
//
// Overview of operation
// - Trap conflict sets bit 15
// - Illegal opcode, address mode, pointer set bit 14
// - Configuration mismatch sets bit 9
// - Master clear pin reset sets bit 7
// - Reset instruction sets bit 6
// - Bit 5 enables watchdog unless fuse set
// - Watchdog time-out sets bit 4
// - Sleep sets bit 3, idle bit 2
// - Brown-out sets bit 1, resets to one
// - Power-on sets bit 0, resets to one
// - Software sets or clears flags, no reset
// - Cold reset loads clock from fuse field
// - Warm reset keeps current oscillator clock
// - Clock-ready delays chosen by oscillator mode
// - Start-up timer counts 1024 oscillator periods
// - PLL modes add 1.5 ms lock wait
// - Power-on extension at most 30 us
// - Brown-out extension at most 100 us
// - Power-up timer holds reset 64 ms
// - Fetch starts at address zero when ready
// - Fail-safe monitor starts 900 us after ready
// - Bits 13-10 and 8 read zero
// - Power-on clears all flags, sets power-on and brown-out
`timescale 1ns/1ns
module rcs_sequencer
  import rcs_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC,   // Power-up timer length
  parameter int unsigned PLL_CYCLES = PLL_LOCK_CYC, // PLL lock wait length
  parameter int unsigned FAILSAFE_CLOCK_MONITOR_CYCLES = FAILSAFE_CLOCK_MONITOR_CYC     // Monitor arming delay
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparators and oscillator, asynchronous
  input wire logic por_supply_ok,
  input wire logic bor_supply_ok,
  input wire logic osc_started,
  input wire logic osc_clk_in,
  // On-chip reset sources, one-cycle pulses
  input wire logic trap_conflict,
  input wire logic illegal_opcode,
  input wire logic illegal_addr_mode,
  input wire logic uninit_pointer,
  input wire logic config_mismatch,
  input wire logic master_clear,
  input wire logic reset_instr,
  input wire logic watchdog_timeout,
  input wire logic sleep_entry,
  input wire logic idle_entry,
  // Configuration fuses and oscillator control
  input wire logic watchdog_enable_fuse,
  input wire logic [2:0] initial_oscillator_fuse,
  input wire logic primary_is_ext_clock,
  input wire logic failsafe_monitor_fuse,
  input wire logic [2:0] current_oscillator_field,
  // Outputs to oscillator and core
  output logic system_reset,
  output logic [2:0] clock_source,
  output logic clock_ready,
  output logic core_fetch_start,
  output logic [23:0] reset_vector,
  output logic watchdog_enabled,
  output logic failsafe_monitor_active
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] async_in;    // Raw asynchronous inputs
  logic [3:0] sync1_ff;    // First stage, read only by second
  logic [3:0] sync2_ff;    // Second stage
  logic [3:0] sync3_ff;    // Third stage
  logic [3:0] filt_ff;     // Level once stages two and three agree
  logic osc_prev_ff;       // Previous filtered oscillator level

  assign async_in = {osc_clk_in, osc_started, bor_supply_ok, por_supply_ok};

  // Three flops, level accepted when the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
      filt_ff <= 4'h0;
      osc_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < 4; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          filt_ff[i] <= sync3_ff[i];
        end
      end
      osc_prev_ff <= filt_ff[3];
    end
  end

  logic por_low;   // Supply below power-on threshold
  logic bor_low;   // Supply below brown-out threshold
  logic osc_rise;  // One oscillator period seen

  assign por_low = !filt_ff[0];
  assign bor_low = !filt_ff[1];
  assign osc_rise = filt_ff[3] && !osc_prev_ff;

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_held_ff;                 // Write address captured
  logic w_held_ff;                  // Write data captured
  logic [ADDR_W-1:0] aw_addr_ff;    // Captured write address
  logic [31:0] w_data_ff;           // Captured write data
  logic [3:0] w_strb_ff;            // Captured byte strobes
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire;                    // Both halves present, do the write
  logic wr_cause;                   // Write hits the cause register
  logic [15:0] flags_ff;            // reset_cause_register contents
  logic [31:0] status_word;         // Status register read value
  rcs_state_e state_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [10:0] ost_cnt_ff;          // Oscillator periods counted
  logic system_reset_ff, clkrdy_ff, fetch_ff, failsafe_clock_monitor_ff, wdten_ff;
  logic [2:0] src_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_cause = wr_fire && (aw_addr_ff == OFS_CAUSE);

  // Address and data channels taken independently, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      if (awready_ff && s_axi_awvalid) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (wready_ff && s_axi_wvalid) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Status register ignores writes; unmapped gets SLVERR
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (aw_addr_ff == OFS_CAUSE || aw_addr_ff == OFS_STATUS) ? 2'h0 : 2'h2;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Status word from sequencer state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_SYSTEM_RESET] = system_reset_ff;
    status_word[STAT_CLKRDY] = clkrdy_ff;
    status_word[STAT_FAILSAFE_CLOCK_MONITOR] = failsafe_clock_monitor_ff;
    status_word[STAT_WDTEN] = wdten_ff;
    status_word[STAT_SRC +: 3] = src_ff;
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (arready_ff && s_axi_arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'h0;
      if (s_axi_araddr == OFS_CAUSE) begin
        rdata_ff <= {16'h0000, flags_ff & CAUSE_IMPL_MASK};
      end else if (s_axi_araddr == OFS_STATUS) begin
        rdata_ff <= status_word;
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= 2'h2;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Reset cause flags
  // ---------------------------------------------------------------
  logic cold_por;     // Power-on event this cycle
  logic cold_bor;     // Brown-out event this cycle
  logic [15:0] nxt_flags;
  logic [15:0] wmask;  // Bits covered by the write strobes

  assign cold_por = por_low;
  assign cold_bor = bor_low && !por_low;

  // Software write first, hardware sets win, cold events override
  always_comb begin
    wmask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}} & CAUSE_IMPL_MASK;
    nxt_flags = flags_ff;
    if (wr_cause) begin
      nxt_flags = (flags_ff & ~wmask) | (w_data_ff[15:0] & wmask);
    end
    if (trap_conflict) nxt_flags[BIT_TRAP] = 1'b1;
    if (illegal_opcode || illegal_addr_mode || uninit_pointer) nxt_flags[BIT_ILLEGAL] = 1'b1;
    if (config_mismatch) nxt_flags[BIT_CMISM] = 1'b1;
    if (master_clear) nxt_flags[BIT_EXTPIN] = 1'b1;
    if (reset_instr) nxt_flags[BIT_SWRST] = 1'b1;
    if (watchdog_timeout) nxt_flags[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (sleep_entry) nxt_flags[BIT_SLEEP] = 1'b1;
    if (idle_entry) nxt_flags[BIT_IDLE] = 1'b1;
    if (cold_bor) begin
      nxt_flags = (flags_ff & BOR_KEEP_MASK);
      nxt_flags[BIT_BOR] = 1'b1;
    end
    if (cold_por) begin
      nxt_flags = CAUSE_RESET;
    end
  end

  // Flag register, power-on value at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= CAUSE_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Watchdog enable, fuse forces it on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdten_ff <= 1'b0;
    end else begin
      wdten_ff <= watchdog_enable_fuse || flags_ff[BIT_SOFT_WATCHDOG_ENABLE];
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  logic warm_evt;       // Any non-cold reset source
  logic mode_start;     // Mode has an oscillator start-up delay
  logic mode_ost;       // Mode runs the start-up timer
  logic mode_pll;       // Mode waits for PLL lock

  assign warm_evt = trap_conflict || illegal_opcode || illegal_addr_mode || uninit_pointer
                    || config_mismatch || master_clear || reset_instr || watchdog_timeout;

  // Delay stages per oscillator mode
  always_comb begin
    mode_start = 1'b1;
    mode_ost = 1'b0;
    mode_pll = 1'b0;
    unique case (src_ff)
      OSC_FRC, OSC_FRCDIV16, OSC_FRCDIVN, OSC_LOW_POWER_RC_MODE: mode_start = 1'b1;
      OSC_FAST_RC_WITH_PLL_MODE: mode_pll = 1'b1;
      OSC_PRI: begin
        mode_start = !primary_is_ext_clock;
        mode_ost = !primary_is_ext_clock;
      end
      OSC_PRIPLL: begin
        mode_start = !primary_is_ext_clock;
        mode_ost = !primary_is_ext_clock;
        mode_pll = 1'b1;
      end
      OSC_SECONDARY_OSCILLATOR_MODE: mode_ost = 1'b1;
    endcase
  end

  // State, timer and outputs of the reset sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_COLD_HOLD;
      tmr_ff <= '0;
      ost_cnt_ff <= 11'h000;
      system_reset_ff <= 1'b1;
      clkrdy_ff <= 1'b0;
      fetch_ff <= 1'b0;
      failsafe_clock_monitor_ff <= 1'b0;
      src_ff <= OSC_FRC;
    end else begin
      fetch_ff <= 1'b0;
      if (por_low || bor_low) begin
        // Cold reset: hold everything until the supply returns
        state_ff <= ST_COLD_HOLD;
        system_reset_ff <= 1'b1;
        clkrdy_ff <= 1'b0;
        failsafe_clock_monitor_ff <= 1'b0;
      end else if (warm_evt && (state_ff == ST_RUN || state_ff == ST_WARM)) begin
        // Warm reset: clock keeps running on the current source
        state_ff <= ST_WARM;
        system_reset_ff <= 1'b1;
        failsafe_clock_monitor_ff <= 1'b0;
        src_ff <= current_oscillator_field;
      end else begin
        unique case (state_ff)
          ST_COLD_HOLD: begin
            state_ff <= flags_ff[BIT_POR] ? ST_POR_EXT : ST_BOR_EXT;
            tmr_ff <= flags_ff[BIT_POR] ? TMR_W'(POR_EXT_CYC - 1) : TMR_W'(BOR_EXT_CYC - 1);
          end
          ST_POR_EXT: begin
            tmr_ff <= tmr_ff - 1'b1;
            if (tmr_ff == '0) begin
              state_ff <= ST_BOR_EXT;
              tmr_ff <= TMR_W'(BOR_EXT_CYC - 1);
            end
          end
          ST_BOR_EXT: begin
            tmr_ff <= tmr_ff - 1'b1;
            if (tmr_ff == '0) begin
              state_ff <= ST_POWER_UP_TIMER;
              tmr_ff <= TMR_W'(POWER_UP_TIMER_CYCLES - 1);
            end
          end
          ST_POWER_UP_TIMER: begin
            tmr_ff <= tmr_ff - 1'b1;
            if (tmr_ff == '0) begin
              state_ff <= ST_OSC_START;
              system_reset_ff <= 1'b0;
              src_ff <= initial_oscillator_fuse;
            end
          end
          ST_OSC_START: begin
            ost_cnt_ff <= 11'h000;
            if (!mode_start || filt_ff[2]) begin
              if (mode_ost) begin
                state_ff <= ST_OST;
              end else if (mode_pll) begin
                state_ff <= ST_PLL;
                tmr_ff <= TMR_W'(PLL_CYCLES - 1);
              end else begin
                state_ff <= ST_RUN;
                clkrdy_ff <= 1'b1;
                fetch_ff <= 1'b1;
                tmr_ff <= TMR_W'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1);
              end
            end
          end
          ST_OST: begin
            if (osc_rise) begin
              ost_cnt_ff <= ost_cnt_ff + 1'b1;
            end
            if (ost_cnt_ff == 11'(OST_PERIODS)) begin
              if (mode_pll) begin
                state_ff <= ST_PLL;
                tmr_ff <= TMR_W'(PLL_CYCLES - 1);
              end else begin
                state_ff <= ST_RUN;
                clkrdy_ff <= 1'b1;
                fetch_ff <= 1'b1;
                tmr_ff <= TMR_W'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1);
              end
            end
          end
          ST_PLL: begin
            tmr_ff <= tmr_ff - 1'b1;
            if (tmr_ff == '0) begin
              state_ff <= ST_RUN;
              clkrdy_ff <= 1'b1;
              fetch_ff <= 1'b1;
              tmr_ff <= TMR_W'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1);
            end
          end
          ST_WARM: begin
            // Released the next cycle, fetch restarts from the vector
            state_ff <= ST_RUN;
            system_reset_ff <= 1'b0;
            fetch_ff <= 1'b1;
            tmr_ff <= TMR_W'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1);
          end
          ST_RUN: begin
            if (tmr_ff != '0) begin
              tmr_ff <= tmr_ff - 1'b1;
            end else begin
              failsafe_clock_monitor_ff <= failsafe_monitor_fuse;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Output wiring
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign system_reset = system_reset_ff;
  assign clock_source = src_ff;
  assign clock_ready = clkrdy_ff;
  assign core_fetch_start = fetch_ff;
  assign reset_vector = RESET_VECTOR;
  assign watchdog_enabled = wdten_ff;
  assign failsafe_monitor_active = failsafe_clock_monitor_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_trap_flag_set: assert property (trap_conflict && !por_low && !bor_low |=> flags_ff[BIT_TRAP])
    else $error("trap flag not set");
  chk_illegal_flag_set: assert property ((illegal_opcode || illegal_addr_mode || uninit_pointer) && !por_low && !bor_low
    |=> flags_ff[BIT_ILLEGAL])
    else $error("illegal flag not set");
  chk_cmism_flag_set: assert property (config_mismatch && !por_low && !bor_low |=> flags_ff[BIT_CMISM])
    else $error("mismatch flag not set");
  chk_pin_flag_set: assert property (master_clear && !por_low && !bor_low |=> flags_ff[BIT_EXTPIN])
    else $error("pin flag not set");
  chk_unimpl_zero: assert property ((flags_ff & ~CAUSE_IMPL_MASK) == 16'h0000)
    else $error("unimplemented bits set");
  chk_por_clears: assert property (por_low |=> flags_ff == CAUSE_RESET)
    else $error("power-on did not clear flags");
  chk_wdt_enable: assert property (##1 wdten_ff == ($past(watchdog_enable_fuse) || $past(flags_ff[BIT_SOFT_WATCHDOG_ENABLE])))
    else $error("watchdog enable wrong");
  chk_warm_release: assert property (state_ff == ST_RUN && warm_evt && !por_low && !bor_low
    |=> system_reset_ff ##1 (!system_reset_ff && fetch_ff))
    else $error("warm reset not one cycle");
  chk_sw_write_quiet: assert property (wr_cause && !warm_evt && state_ff == ST_RUN && !por_low && !bor_low
    |=> !system_reset_ff)
    else $error("flag write caused reset");
  chk_failsafe_clock_monitor_delay: assert property ($rose(fetch_ff) |-> !failsafe_clock_monitor_ff [*8])
    else $error("monitor armed too early");

  cov_cold_start: cover property ($rose(clkrdy_ff) ##[1:1000] $rose(failsafe_clock_monitor_ff));
  cov_warm_reset: cover property (state_ff == ST_WARM);
  cov_sw_write: cover property (wr_cause && trap_conflict);

endmodule : rcs_sequencer

// [test/rcs_osc_model.sv]
// Oscillator block model: start-up delay and a slow oscillator clock
`timescale 1ns/1ns
module rcs_osc_model (
  input wire logic aclk,
  input wire logic supply_ok,
  input wire logic system_reset,
  output logic osc_started,
  output logic osc_clk_in
);
  logic run_ff; // Oscillator enabled
  logic [7:0] up_ff; // Start-up delay count
  logic [2:0] div_ff; // Divider for the oscillator clock
  // Starts once system reset falls, stops on supply loss
  always_ff @(posedge aclk) begin
    if (!supply_ok) begin
      run_ff <= 1'b0;
      up_ff <= 8'h00;
      div_ff <= 3'h0;
    end else begin
      if (!system_reset) run_ff <= 1'b1;
      if (run_ff && up_ff != 8'hFF) up_ff <= up_ff + 8'h01;
      if (osc_started) div_ff <= div_ff + 3'h1;
    end
  end
  assign osc_started = up_ff >= 8'h14; // Start-up delay over
  assign osc_clk_in = osc_started & div_ff[2]; // Stands still until started
endmodule : rcs_osc_model

// [test/tb_reset_cause_and_startup_sequencer.sv]
// Testbench of the reset cause register and start-up sequencer
`timescale 1ns/1ns
module tb_reset_cause_and_startup_sequencer
  import rcs_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_started, osc_clk_in;
  logic por_supply_ok, bor_supply_ok, system_reset, clock_ready, core_fetch_start;
  logic watchdog_enabled, failsafe_monitor_active;
  logic [2:0] clock_source;
  logic [23:0] reset_vector;
  logic wd_fuse; // Watchdog enable fuse level
  logic [2:0] osc_fuse; // Oscillator selected after a cold reset
  logic [1:0] bresp_seen; // Write response of the last write
  logic [9:0] ev; // One-hot event pulses
  wire logic trap_conflict, illegal_opcode, illegal_addr_mode, uninit_pointer, config_mismatch;
  wire logic master_clear, reset_instr, watchdog_timeout, sleep_entry, idle_entry;
  int fail_count = 0, checks_done = 0, cyc = 0;
  // Rows: event pulse beside the flags it should leave set
  localparam logic [25:0] ROWS [10] = '{{10'h200, 16'h8000}, {10'h100, 16'h4000}, {10'h080, 16'h4000},
    {10'h040, 16'h4000}, {10'h020, 16'h0200}, {10'h010, 16'h0080}, {10'h008, 16'h0040},
    {10'h004, 16'h0010}, {10'h002, 16'h0008}, {10'h001, 16'h0004}};
  assign {trap_conflict, illegal_opcode, illegal_addr_mode, uninit_pointer, config_mismatch, master_clear,
    reset_instr, watchdog_timeout, sleep_entry, idle_entry} = ev;
  rcs_sequencer #(.POWER_UP_TIMER_CYCLES(20), .PLL_CYCLES(10), .FAILSAFE_CLOCK_MONITOR_CYCLES(12)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .por_supply_ok, .bor_supply_ok, .osc_started, .osc_clk_in, .trap_conflict,
    .illegal_opcode, .illegal_addr_mode, .uninit_pointer, .config_mismatch, .master_clear, .reset_instr,
    .watchdog_timeout, .sleep_entry, .idle_entry, .watchdog_enable_fuse(wd_fuse), .initial_oscillator_fuse(osc_fuse),
    .primary_is_ext_clock(1'b0), .failsafe_monitor_fuse(1'b1), .current_oscillator_field(OSC_FRC),
    .system_reset, .clock_source, .clock_ready, .core_fetch_start, .reset_vector, .watchdog_enabled,
    .failsafe_monitor_active);
  rcs_osc_model far (.aclk, .supply_ok(por_supply_ok & bor_supply_ok), .system_reset, .osc_started, .osc_clk_in);
  // Clock and hang limit
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // AXI4-Lite write, each channel released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  // AXI4-Lite read, data and response taken at the handshake
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = {s_axi_rresp, s_axi_rdata[29:0]};
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, por_supply_ok, bor_supply_ok, wd_fuse} = '0;
    osc_fuse = OSC_PRI;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_CAUSE, rd);
    chk(rd, 32'h0003);
    por_supply_ok <= 1'b1;
    bor_supply_ok <= 1'b1;
    wait (clock_ready === 1'b1);
    #1;
    chk({clock_source, reset_vector, core_fetch_start}, {OSC_PRI, 24'h000000, 1'b1});
    repeat (20) @(posedge aclk);
    chk(failsafe_monitor_active, 1'b1);
    $display("cold start done");
    foreach (ROWS[i]) begin
      axw(OFS_CAUSE, 32'h0);
      @(posedge aclk) ev <= ROWS[i][25:16];
      @(posedge aclk) ev <= '0;
      axr(OFS_CAUSE, rd);
      chk(rd, ROWS[i][15:0]);
    end
    chk(clock_source, OSC_FRC);
    chk(watchdog_enabled, 1'b0);
    wd_fuse <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(watchdog_enabled, 1'b1);
    wd_fuse <= 1'b0;
    axw(OFS_CAUSE, 32'hFFFF_FFFF);
    chk(bresp_seen, 2'h0);
    axw(8'h10, 32'h0000_0001);
    chk(bresp_seen, 2'h2);
    axr(OFS_CAUSE, rd);
    chk(rd, 32'hC2FF);
    chk({system_reset, watchdog_enabled}, 2'b01);
    axr(8'h10, rd);
    chk(rd, 32'h8000_0000);
    $display("register tests done");
    osc_fuse <= OSC_PRIPLL;
    bor_supply_ok <= 1'b0;
    repeat (8) @(posedge aclk);
    bor_supply_ok <= 1'b1;
    repeat (8) @(posedge aclk);
    wait (clock_ready === 1'b1);
    axr(OFS_CAUSE, rd);
    chk(rd, 32'h00A3);
    chk(clock_source, OSC_PRIPLL);
    $display("brown-out test done");
    report_and_stop();
  end
endmodule : tb_reset_cause_and_startup_sequencer
